/* File: rtl/fdisk_host.sv */
// Host controller that drives a flash disk through its standard parallel pin interface.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
// Operation
// - In 16-bit mode hold lowest address low.
// - Chip select low only during an access.
// - Output enable low with chip select for reads.
// - Write enable low only for writes.
// - Single device ties position strap to 00; here the strap is {0, CTRL_POS}, which resets to 01 until software clears it.
module fdisk_host
    import fdisk_host_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [ADDR_W-1:0] dev_addr,
    input wire logic [DATA_W-1:0] dev_data_in,
    output logic [DATA_W-1:0] dev_data_out,
    output logic [DATA_W-1:0] dev_data_oe,
    output logic chip_select_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic bus_width_strap,
    output logic [1:0] cascade_position_strap,
    output logic lock_n,
    output logic reset_in_n,
    input wire logic busy_n,
    input wire logic irq_n
);

    typedef struct packed {
        phase_t phase;
        logic [3:0] count;
        logic [7:0] rst_count;
        logic write;
        logic wide;
        logic pos;
        logic lock;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic [IRQ_BITS-1:0] istat;
        logic [IRQ_BITS-1:0] imask;
        logic busy_seen;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] doe;
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic [IRQ_BITS-1:0] event_set;
    logic [IRQ_BITS-1:0] w1c;
    logic wr_acc;
    logic rd_acc;

    // Register decode and the device access sequencer share one next-state process.
    always_comb begin
        next_cur = cur;
        event_set = '0;
        w1c = '0;
        wr_acc = psel && penable && pwrite && !cur.pready;
        rd_acc = psel && penable && !pwrite && !cur.pready;
        next_cur.pready = 1'b0;
        next_cur.pslverr = 1'b0;
        // Answer every access in the cycle after the access phase starts.
        if (psel && penable && !cur.pready) begin
            next_cur.pready = 1'b1;
        end
        if (rd_acc) begin
            next_cur.prdata = 32'h0;
            if (paddr == OFF_CTRL) begin
                next_cur.prdata = {26'h0, !cur.rst_n, cur.lock, cur.pos, cur.wide, cur.write,
                                   cur.phase != ST_IDLE};
            end else if (paddr == OFF_ADDR) begin
                next_cur.prdata = {19'h0, cur.addr};
            end else if (paddr == OFF_WDATA) begin
                next_cur.prdata = {16'h0, cur.wdata};
            end else if (paddr == OFF_RDATA) begin
                next_cur.prdata = {16'h0, cur.rdata};
            end else if (paddr == OFF_STATUS) begin
                next_cur.prdata = {29'h0, !irq_n, !busy_n, cur.phase != ST_IDLE};
            end else if (paddr == OFF_IRQ_STAT) begin
                next_cur.prdata = {29'h0, cur.istat};
            end else if (paddr == OFF_IRQ_MASK) begin
                next_cur.prdata = {29'h0, cur.imask};
            end else begin
                next_cur.pslverr = 1'b1;
            end
        end
        if (wr_acc) begin
            if (paddr == OFF_CTRL) begin
                // Configuration only changes while the pins are quiet.
                if (cur.phase == ST_IDLE) begin
                    next_cur.write = pwdata[CTRL_WRITE];
                    next_cur.wide = pwdata[CTRL_WIDE];
                    // Entering 16-bit mode drops the lowest address line at once, not at the next access.
                    if (pwdata[CTRL_WIDE]) begin
                        next_cur.addr[0] = 1'b0;
                    end
                    next_cur.pos = pwdata[CTRL_POS];
                    next_cur.lock = pwdata[CTRL_LOCK];
                    if (pwdata[CTRL_RESET]) begin
                        next_cur.phase = ST_RESET;
                        next_cur.rst_count = RESET_COUNT;
                        next_cur.rst_n = 1'b0;
                        next_cur.busy_seen = 1'b0;
                    end else if (pwdata[CTRL_GO]) begin
                        next_cur.phase = ST_SETUP;
                    end
                end
            end else if (paddr == OFF_ADDR) begin
                // The lowest line is kept low in 16-bit mode, so the idle pin obeys it too.
                next_cur.addr = {pwdata[ADDR_W-1:1], pwdata[0] && !cur.wide};
            end else if (paddr == OFF_WDATA) begin
                next_cur.wdata = pwdata[DATA_W-1:0];
            end else if (paddr == OFF_IRQ_STAT) begin
                w1c = pwdata[IRQ_BITS-1:0];
            end else if (paddr == OFF_IRQ_MASK) begin
                next_cur.imask = pwdata[IRQ_BITS-1:0];
            end else if (paddr != OFF_RDATA && paddr != OFF_STATUS) begin
                next_cur.pslverr = 1'b1;
            end
        end
        // Access sequencer on the device pins.
        case (cur.phase)
            ST_IDLE: begin
                next_cur.cs_n = 1'b1;
                next_cur.oe_n = 1'b1;
                next_cur.we_n = 1'b1;
                next_cur.doe = '0;
            end
            ST_RESET: begin
                // The device stays in reset while the pin is low.
                if (cur.rst_count == 8'h00) begin
                    next_cur.rst_n = 1'b1;
                    next_cur.phase = ST_IDLE;
                end else begin
                    next_cur.rst_count = cur.rst_count - 8'h01;
                end
            end
            ST_SETUP: begin
                // In 16-bit mode the lowest address line is forced low.
                next_cur.addr[0] = cur.wide ? 1'b0 : cur.addr[0];
                next_cur.cs_n = 1'b0;
                next_cur.oe_n = cur.write;
                next_cur.we_n = !cur.write;
                next_cur.dout = cur.wide ? cur.wdata : {8'h00, cur.wdata[7:0]};
                // Upper byte is left undriven in 8-bit mode.
                next_cur.doe = cur.write ? (cur.wide ? 16'hFFFF : 16'h00FF) : 16'h0000;
                next_cur.count = ACCESS_COUNT;
                next_cur.phase = ST_STROBE;
            end
            ST_STROBE: begin
                if (cur.count == 4'h1) begin
                    if (!cur.write) begin
                        next_cur.rdata = cur.wide ? dev_data_in : {8'h00, dev_data_in[7:0]};
                    end
                    next_cur.oe_n = 1'b1;
                    next_cur.we_n = 1'b1;
                    next_cur.phase = ST_HOLD;
                end else begin
                    next_cur.count = cur.count - 4'h1;
                end
            end
            ST_HOLD: begin
                // Data and address stay one cycle past the strobe edge for hold time.
                next_cur.cs_n = 1'b1;
                next_cur.doe = '0;
                next_cur.phase = ST_IDLE;
                event_set[IRQ_DONE] = 1'b1;
            end
            default: begin
                next_cur.phase = ST_IDLE;
            end
        endcase
        // Busy released after a reset marks the end of the boot download.
        if (cur.rst_n && busy_n && !cur.busy_seen) begin
            next_cur.busy_seen = 1'b1;
            event_set[IRQ_READY] = 1'b1;
        end
        event_set[IRQ_DEV] = !irq_n;
        // A new event wins over a clear in the same cycle.
        next_cur.istat = (cur.istat & ~w1c) | event_set;
        next_cur.irq = |(next_cur.istat & cur.imask);
    end

    // State register; every output is taken from here.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
            cur.phase <= ST_IDLE;
            cur.wide <= CTRL_RESET_VALUE[CTRL_WIDE];
            cur.pos <= CTRL_RESET_VALUE[CTRL_POS];
            cur.lock <= CTRL_RESET_VALUE[CTRL_LOCK];
            cur.imask <= IRQ_MASK_RESET;
            cur.cs_n <= 1'b1;
            cur.oe_n <= 1'b1;
            cur.we_n <= 1'b1;
            cur.rst_n <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // Strap and pin outputs straight from the state register.
    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign irq = cur.irq;
    assign dev_addr = cur.addr;
    assign dev_data_out = cur.dout;
    assign dev_data_oe = cur.doe;
    assign chip_select_n = cur.cs_n;
    assign output_enable_n = cur.oe_n;
    assign write_enable_n = cur.we_n;
    assign bus_width_strap = cur.wide;
    assign cascade_position_strap = {1'b0, cur.pos};
    assign lock_n = !cur.lock;
    assign reset_in_n = cur.rst_n;

endmodule : fdisk_host

/* File: rtl/fdisk_host_pkg.sv */
// Package with constants, register offsets and types for the flash disk host controller.
package fdisk_host_pkg;
    // Register byte offsets on the APB side.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_WDATA = 8'h08;
    localparam logic [7:0] OFF_RDATA = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    // Control register fields.
    localparam int CTRL_GO = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_WIDE = 2;
    localparam int CTRL_POS = 3;
    localparam int CTRL_LOCK = 4;
    localparam int CTRL_RESET = 5;
    // Status register fields.
    localparam int STAT_BUSY = 0;
    localparam int STAT_DEV_BUSY = 1;
    localparam int STAT_DEV_IRQ = 2;
    // Interrupt status fields.
    localparam int IRQ_DONE = 0;
    localparam int IRQ_READY = 1;
    localparam int IRQ_DEV = 2;
    localparam int IRQ_BITS = 3;
    // Reset values.
    localparam logic [5:0] CTRL_RESET_VALUE = 6'h3C;
    localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 3'h0;
    // Strobe timing: device access time of 64 ns, rounded up to whole cycles.
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACCESS_NS = 64;
    localparam int ACCESS_CYCLES = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] ACCESS_COUNT = 4'(ACCESS_CYCLES);
    // Reset pulse held on the device reset pin, 1 us.
    localparam int RESET_NS = 1000;
    localparam logic [7:0] RESET_COUNT = 8'((RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Widths of the device pins.
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;

    typedef enum {ST_IDLE, ST_RESET, ST_SETUP, ST_STROBE, ST_HOLD} phase_t;
endpackage : fdisk_host_pkg

/* File: tb/fdisk_host_monitor.sv */
// Checker of the host controller pin behaviour towards the flash disk.
`timescale 1ns/10ps
module fdisk_host_monitor
    import fdisk_host_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] dev_addr,
    input wire logic [DATA_W-1:0] dev_data_oe,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic bus_width_strap,
    input wire logic [1:0] cascade_position_strap,
    input wire logic reset_in_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // An access holds select for eight cycles and the read strobe for seven.
    sequence s_sel; !chip_select_n [*8] ##1 chip_select_n; endsequence
    sequence s_stb; !output_enable_n [*7] ##1 output_enable_n; endsequence
    property p_sel; $fell(chip_select_n) |-> s_sel; endproperty
    property p_stb; $fell(output_enable_n) |-> s_stb; endproperty
    property p_oe; !output_enable_n |-> !chip_select_n && write_enable_n; endproperty
    property p_we; !write_enable_n |-> !chip_select_n; endproperty
    property p_drv; |dev_data_oe |-> !chip_select_n && output_enable_n; endproperty
    property p_hi; !bus_width_strap |-> dev_data_oe[15:8] == 8'h00; endproperty
    property p_a0; bus_width_strap && !chip_select_n |-> !dev_addr[0]; endproperty
    property p_pos; cascade_position_strap[1] == 1'b0; endproperty
    property p_rst; !reset_in_n |-> chip_select_n; endproperty
    // A write holds its strobe for seven cycles while the host drives the low byte.
    sequence s_wstb; !write_enable_n [*7] ##1 write_enable_n; endsequence
    property p_wstb; $fell(write_enable_n) |-> s_wstb; endproperty
    property p_wdrv; !write_enable_n |-> dev_data_oe[7:0] == 8'hFF; endproperty
    property p_alo; bus_width_strap |-> !dev_addr[0]; endproperty
    a_sel: assert property (p_sel) else $error("select window wrong");
    a_stb: assert property (p_stb) else $error("read strobe wrong");
    a_oe: assert property (p_oe) else $error("read strobe alone");
    a_we: assert property (p_we) else $error("write strobe alone");
    a_drv: assert property (p_drv) else $error("bus contention");
    a_hi: assert property (p_hi) else $error("upper byte driven");
    a_a0: assert property (p_a0) else $error("low address set");
    a_pos: assert property (p_pos) else $error("position strap high");
    a_rst: assert property (p_rst) else $error("access in reset");
    a_wstb: assert property (p_wstb) else $error("write strobe wrong");
    a_wdrv: assert property (p_wdrv) else $error("write data not driven");
    a_alo: assert property (p_alo) else $error("low address set when idle");
endmodule : fdisk_host_monitor
bind fdisk_host fdisk_host_monitor mon_u (.clk, .rstn, .dev_addr, .dev_data_oe,
    .chip_select_n, .output_enable_n, .write_enable_n, .bus_width_strap,
    .cascade_position_strap, .reset_in_n);

/* File: tb/fdisk_dev_model.sv */
// Behavioural model of the flash disk at the far side of the pins.
`timescale 1ns/10ps
module fdisk_dev_model (
    input wire logic clk,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic bus_width_strap,
    input wire logic [1:0] cascade_position_strap,
    input wire logic reset_in_n,
    input wire logic [15:0] dev_data_out,
    input wire logic [15:0] dev_data_oe,
    input wire logic raise_irq,
    output logic [15:0] dev_data_in,
    output logic busy_n,
    output logic irq_n
);
    logic [15:0] mem = 16'h0000;
    logic [4:0] boot = 5'h00;
    logic sel;
    // Only device 00 answers; the select strobe gates the memory writes and the read data, not busy or the interrupt.
    assign sel = !chip_select_n && cascade_position_strap == 2'b00;
    // Boot download runs 20 cycles after reset; busy is released to the pull-up.
    always @(posedge clk) begin
        if (!reset_in_n) boot <= 5'h00;
        else if (boot != 5'h14) boot <= boot + 5'h01;
        if (sel && !write_enable_n && bus_width_strap) mem <= dev_data_out;
        if (sel && !write_enable_n && !bus_width_strap) mem[7:0] <= dev_data_out[7:0];
    end
    assign busy_n = (boot == 5'h14);
    assign irq_n = !raise_irq;
    // Released lines show the inverse so stale data never looks valid; upper pull-ups in 8-bit.
    assign dev_data_in = (sel && !output_enable_n) ? (bus_width_strap ? mem : {8'hFF, mem[7:0]})
        : ~mem;
endmodule : fdisk_dev_model

/* File: tb/flash_disk_host_pin_interface_tb_top.sv */
// Testbench of the flash disk host controller.
`timescale 1ns/10ps
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin fails++; $display("wrong value %s expected %h seen %h", n, e, v); end end
module flash_disk_host_pin_interface_tb_top
    import fdisk_host_pkg::*;
;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, raise = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [ADDR_W-1:0] dev_addr;
    logic [15:0] din, dout, doe;
    logic cs_n, oe_n, we_n, wide, lock_n, rst_n, busy_n, irq_n;
    logic [1:0] pos;
    int fails = 0, checked = 0, cycles = 0;
    fdisk_host dut_u (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq, .dev_addr, .dev_data_in(din), .dev_data_out(dout), .dev_data_oe(doe),
        .chip_select_n(cs_n), .output_enable_n(oe_n), .write_enable_n(we_n),
        .bus_width_strap(wide), .cascade_position_strap(pos), .lock_n, .reset_in_n(rst_n),
        .busy_n, .irq_n);
    fdisk_dev_model dev_u (.clk, .chip_select_n(cs_n), .output_enable_n(oe_n),
        .write_enable_n(we_n), .bus_width_strap(wide), .cascade_position_strap(pos),
        .reset_in_n(rst_n), .dev_data_out(dout), .dev_data_oe(doe), .raise_irq(raise),
        .dev_data_in(din), .busy_n, .irq_n);
    always #5 clk = ~clk;
    // A hung wait is cut short here rather than by each loop.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    // One APB transfer: request held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd
    task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
        logic [31:0] r;
        rd(a, r);
        while (r[b] !== v) rd(a, r);
    endtask : wait_bit
    // Reset state, then release of the device and its boot download.
    task automatic t_boot();
        logic [31:0] r;
        `CHK("reset pin", 1'b0, rst_n)
        `CHK("strap", 2'b01, pos)
        rd(OFF_CTRL, r); `CHK("ctrl", 32'h3C, r)
        wr(OFF_CTRL, 32'h34); // Position 00, lock on, 16-bit, reset.
        wait_bit(OFF_IRQ_STAT, IRQ_READY, 1'b1);
        `CHK("reset pin", 1'b1, rst_n)
        `CHK("strap", 2'b00, pos)
        `CHK("lock", 1'b0, lock_n)
        rd(OFF_STATUS, r);
        `CHK("device busy", 1'b0, r[STAT_DEV_BUSY])
        wr(OFF_IRQ_STAT, 32'h2);
        rd(OFF_IRQ_STAT, r); `CHK("ready cleared", 1'b0, r[IRQ_READY])
    endtask : t_boot
    // Write then read back one word at the given width.
    task automatic t_access(input logic w16, input logic [15:0] d, input logic [15:0] x);
        logic [31:0] r, c;
        c = 32'h10 | {29'h0, w16, 2'b00};
        wr(OFF_CTRL, c);
        `CHK("width strap", w16, wide)
        wr(OFF_ADDR, 32'h1235);
        rd(OFF_ADDR, r); `CHK("addr", w16 ? 32'h1234 : 32'h1235, r)
        wr(OFF_WDATA, {16'h0, d});
        wr(OFF_CTRL, c | 32'h3);
        wait_bit(OFF_STATUS, STAT_BUSY, 1'b0);
        wr(OFF_CTRL, c | 32'h1);
        wait_bit(OFF_STATUS, STAT_BUSY, 1'b0);
        rd(OFF_RDATA, r); `CHK("rdata", {16'h0, x}, r)
        rd(OFF_IRQ_STAT, r); `CHK("done", 1'b1, r[IRQ_DONE])
        `CHK("select idle", 1'b1, cs_n)
    endtask : t_access
    // Device interrupt masked, unmasked and cleared.
    task automatic t_irq();
        logic [31:0] r;
        wr(OFF_IRQ_STAT, 32'h7);
        raise <= 1;
        repeat (4) @(posedge clk);
        `CHK("masked irq", 1'b0, irq)
        rd(OFF_STATUS, r);
        `CHK("device irq", 1'b1, r[STAT_DEV_IRQ])
        wr(OFF_IRQ_MASK, 32'h4);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        raise <= 0;
        wr(OFF_IRQ_STAT, 32'h7);
        repeat (3) @(posedge clk);
        `CHK("cleared irq", 1'b0, irq)
    endtask : t_irq
    initial begin
        logic [31:0] r;
        logic e;
        repeat (10) @(posedge clk);
        rstn <= 1;
        t_boot();
        t_access(1'b1, 16'hA5C3, 16'hA5C3);
        t_access(1'b0, 16'hBEEF, 16'h00EF);
        t_irq();
        wr(OFF_CTRL, 32'h0);
        `CHK("lock released", 1'b1, lock_n)
        apb(1'b0, 8'h1C, 32'h0, r, e);
        `CHK("unmapped error", 1'b1, e)
        final_report();
    end
endmodule : flash_disk_host_pin_interface_tb_top
